// ===== ext_irq_detect.sv
// One external interrupt pin: synchroniser and trigger detection
`timescale 1ns/1ps
`default_nettype none
module ext_irq_detect
  import power_seq_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       pin,
  input  wire logic       func_en,
  input  wire logic [2:0] mode,
  output logic            event_hit
);

  logic sync_a;
  logic sync_b;
  logic prev;

  // Pins come from outside the always-on domain of the core
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  always_comb begin
    event_hit = 1'b0;
    if (func_en) begin
      unique case (mode)
        TRIG_LOW:     event_hit = !sync_b;
        TRIG_HIGH:    event_hit = sync_b;
        TRIG_FALLING: event_hit = prev && !sync_b;
        TRIG_RISING:  event_hit = !prev && sync_b;
        TRIG_BOTH:    event_hit = prev != sync_b;
        default:      event_hit = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== power_far_side.sv
// Regulator, CPU wrapper and memory stand-ins beyond the sequencer
`timescale 1ns/1ps
`default_nettype none
module power_far_side #(
  parameter int unsigned DLY = 3
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic core_power_enable,
  input  wire logic idle_request,
  input  wire logic sdram_self_refresh,
  output logic      rail_on,
  output logic      cpu_idle_ack,
  output logic      self_refresh_ack
);
  logic [7:0] ack_cnt;
  logic [7:0] ref_cnt;

  assign rail_on = core_power_enable;

  // Acknowledge is late on purpose so the request must be held
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) ack_cnt <= 8'h0;
    else ack_cnt <= idle_request ? ack_cnt + {7'h0, ack_cnt < 8'hff} : 8'h0;
  end
  assign cpu_idle_ack = idle_request && ack_cnt >= DLY;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) ref_cnt <= 8'h0;
    else ref_cnt <= sdram_self_refresh ? ref_cnt + {7'h0, ref_cnt < 8'hff}
                                       : 8'h0;
  end
  assign self_refresh_ack = ref_cnt >= DLY;
endmodule
`default_nettype wire

// ===== power_seq_checker_properties.sv
// Port-level checks of the sleep and wake-up power sequencer
`timescale 1ns/1ps
`default_nettype none
module power_seq_checker
  import power_seq_pkg::*;
#(
  parameter int unsigned WAKE_RST_CYCLES = WAKE_RESET_CYCLES
) (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       battery_fault_n,
  input wire logic       cpu_idle_ack,
  input wire logic       core_power_enable,
  input wire logic       core_reset_n,
  input wire logic       idle_mode,
  input wire logic [2:0] sdram_protect
);
  logic [31:0] low_cnt;
  logic        wake_seen;
  logic        pwr_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Length of the current low stretch of the core reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) low_cnt <= 32'h0;
    else low_cnt <= core_reset_n ? 32'h0 : low_cnt + 32'h1;
  end

  // Marks a reset stretch that began with a wake, not with rst_b
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_q     <= 1'b1;
      wake_seen <= 1'b0;
    end else begin
      pwr_q <= core_power_enable;
      if (core_power_enable && !pwr_q) wake_seen <= 1'b1;
      else if (core_reset_n) wake_seen <= 1'b0;
    end
  end

  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_wait_state;
    hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait_state: assert property (p_wait_state)
    else $error("wait state not exactly one cycle");
  property p_battery_hold;
    (!battery_fault_n)[*4] ##0 !core_power_enable |=> !core_power_enable;
  endproperty
  a_battery_hold: assert property (p_battery_hold)
    else $error("woke while battery fault low");
  property p_wake_reset;
    $rose(core_power_enable) |-> !core_reset_n;
  endproperty
  a_wake_reset: assert property (p_wake_reset)
    else $error("power back without internal reset");
  property p_wake_len;
    $rose(core_reset_n) && wake_seen |-> low_cnt == WAKE_RST_CYCLES;
  endproperty
  a_wake_len: assert property (p_wake_len)
    else $error("wake reset length wrong");
  property p_protect;
    sdram_protect == 3'h7 || sdram_protect == 3'h0;
  endproperty
  a_protect: assert property (p_protect)
    else $error("memory protect code invalid");
  property p_idle_ack;
    $rose(idle_mode) |-> $past(cpu_idle_ack) || $past(cpu_idle_ack, 2);
  endproperty
  a_idle_ack: assert property (p_idle_ack)
    else $error("idle entered without acknowledge");
  property p_sleep_power;
    $fell(core_power_enable) |-> core_reset_n;
  endproperty
  a_sleep_power: assert property (p_sleep_power)
    else $error("power dropped during reset");
endmodule

bind sleep_wakeup_power_sequencer power_seq_checker #(
  .WAKE_RST_CYCLES(WAKE_RST_CYCLES)
) chk_u (
  .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .battery_fault_n(battery_fault_n), .cpu_idle_ack(cpu_idle_ack),
  .core_power_enable(core_power_enable), .core_reset_n(core_reset_n),
  .idle_mode(idle_mode), .sdram_protect(sdram_protect)
);
`default_nettype wire

// ===== power_seq_pkg.sv
// Shared constants and types for the sleep and wake-up power sequencer
package power_seq_pkg;

  localparam int unsigned EXT_PINS = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CLOCK_GATE_CTRL = 8'h00;
  localparam logic [7:0] OFS_MISC_CONTROL    = 8'h04;
  localparam logic [7:0] OFS_GENERAL_STATUS  = 8'h08;
  localparam logic [7:0] OFS_GENERAL_STATUS2 = 8'h0c;
  localparam logic [7:0] OFS_EXT_IRQ_MASK    = 8'h10;
  localparam logic [7:0] OFS_EXT_IRQ_PENDING = 8'h14;
  localparam logic [7:0] OFS_SOURCE_PENDING  = 8'h18;
  localparam logic [7:0] OFS_REFRESH_CTRL    = 8'h1c;
  localparam logic [7:0] OFS_EXT_IRQ_FUNC    = 8'h20;
  localparam logic [7:0] OFS_TRIG_LOW        = 8'h24;
  localparam logic [7:0] OFS_TRIG_HIGH       = 8'h28;
  localparam logic [7:0] OFS_POWER_STATUS    = 8'h2c;

  // Field positions
  localparam int unsigned IDLE_BIT      = 2;
  localparam int unsigned SLEEP_BIT     = 3;
  localparam int unsigned PULLUP_LSB    = 0;
  localparam int unsigned USB_LSB       = 12;
  localparam int unsigned SDRAM_LSB     = 17;
  localparam int unsigned SELF_REF_BIT  = 22;
  localparam int unsigned WAKE_FLAG_BIT = 2;
  localparam int unsigned USER_LSB      = 3;
  localparam int unsigned SRC_EXT_LSB   = 0;
  localparam int unsigned SRC_RTC_BIT   = 5;
  localparam int unsigned LOW_PINS      = 4;
  localparam int unsigned TRIG_STRIDE   = 4;
  localparam int unsigned PINS_PER_TRIG = 8;

  // Field values
  localparam logic [2:0]  SDRAM_PROTECT = 3'h7;
  localparam logic [2:0]  SDRAM_RELEASE = 3'h0;
  localparam logic [1:0]  USB_SUSPEND   = 2'h3;
  localparam logic [31:0] RESET_ZERO    = 32'h0000_0000;
  localparam logic [15:0] MASK_RESET    = 16'hffff;

  // Wake reset length in crystal periods; the crystal is ref_clk itself
  localparam int unsigned WAKE_RESET_PERIODS = 65535;
  localparam int unsigned XTAL_PER_CLK       = 1;
  localparam int unsigned WAKE_RESET_CYCLES  =
    WAKE_RESET_PERIODS / XTAL_PER_CLK;

  // Trigger modes of one external interrupt pin
  typedef enum logic [2:0] {
    TRIG_LOW     = 3'b000,
    TRIG_HIGH    = 3'b001,
    TRIG_FALLING = 3'b010,
    TRIG_RISING  = 3'b011,
    TRIG_BOTH    = 3'b100
  } trig_mode_t;

  typedef enum logic [2:0] {
    ST_RUN       = 3'b000,
    ST_IDLE_REQ  = 3'b001,
    ST_IDLE      = 3'b010,
    ST_SLEEP     = 3'b011,
    ST_WAKE_RST  = 3'b100
  } power_state_t;

  // Captured AHB address phase
  typedef struct packed {
    logic [7:0] addr;
    logic       write;
  } ahb_req_t;

endpackage

// ===== sleep_wakeup_power_sequencer.sv
// Sleep, idle and wake-up power sequencing with an AHB-Lite register port
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_power_sequencer
  import power_seq_pkg::*;
#(
  parameter int unsigned WAKE_RST_CYCLES = WAKE_RESET_CYCLES
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic [EXT_PINS-1:0] ext_irq_pin,
  input  wire logic                rtc_alarm,
  input  wire logic                battery_fault_n,
  input  wire logic                cpu_idle_ack,
  input  wire logic                idle_wake_irq,
  input  wire logic                self_refresh_ack,
  output logic                     core_power_enable,
  output logic                     core_reset_n,
  output logic                     idle_request,
  output logic                     idle_mode,
  output logic [2:0]               sdram_protect,
  output logic [1:0]               usb_pad_ctrl,
  output logic [1:0]               data_pullup_ctrl,
  output logic                     sdram_self_refresh,
  output logic                     ext_irq_request
);

  power_state_t state;
  ahb_req_t     req;
  logic         dphase;
  logic [15:0]  wake_count;
  logic [31:0]  misc_control;
  logic [31:0]  general_status;
  logic         wake_flag;
  logic [1:0]   clock_gate_ctrl;
  logic [15:0]  ext_irq_mask;
  logic [15:0]  ext_irq_pending;
  logic [5:0]   source_pending;
  logic [15:0]  ext_irq_func;
  logic [2:0]   trig_mode [EXT_PINS];
  logic [EXT_PINS-1:0] pin_hit;
  logic         wr;
  logic         wake_src;
  logic         wake_go;
  logic         count_done;
  logic [31:0]  next_rdata;

  genvar g;
  generate
    for (g = 0; g < EXT_PINS; g++) begin : pin_det
      ext_irq_detect u_det (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .pin       (ext_irq_pin[g]),
        .func_en   (ext_irq_func[g]),
        .mode      (trig_mode[g]),
        .event_hit (pin_hit[g])
      );
    end
  endgenerate

  // Bus slave: one wait state on every transfer so read data is registered
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      req       <= '0;
      dphase    <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= RESET_ZERO;
    end else if (dphase) begin
      dphase    <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= req.write ? RESET_ZERO : next_rdata;
    end else if (hsel && htrans[1] && hready) begin
      req.addr  <= haddr[7:0];
      req.write <= hwrite;
      dphase    <= 1'b1;
      hreadyout <= 1'b0;
    end
  end

  assign wr = dphase && req.write;

  always_comb begin
    next_rdata = RESET_ZERO;
    unique case (req.addr)
      OFS_CLOCK_GATE_CTRL: next_rdata[SLEEP_BIT:IDLE_BIT] = clock_gate_ctrl;
      OFS_MISC_CONTROL:    next_rdata = misc_control;
      OFS_GENERAL_STATUS:  next_rdata = general_status;
      OFS_GENERAL_STATUS2: next_rdata[WAKE_FLAG_BIT] = wake_flag;
      OFS_EXT_IRQ_MASK:    next_rdata[15:0] = ext_irq_mask;
      OFS_EXT_IRQ_PENDING: next_rdata[15:0] = ext_irq_pending;
      OFS_SOURCE_PENDING:  next_rdata[5:0] = source_pending;
      OFS_REFRESH_CTRL:    next_rdata[SELF_REF_BIT] = sdram_self_refresh;
      OFS_EXT_IRQ_FUNC:    next_rdata[15:0] = ext_irq_func;
      OFS_TRIG_LOW, OFS_TRIG_HIGH: begin
        for (int i = 0; i < PINS_PER_TRIG; i++) begin
          next_rdata[i*TRIG_STRIDE +: 3] = (req.addr == OFS_TRIG_HIGH)
            ? trig_mode[i + PINS_PER_TRIG] : trig_mode[i];
        end
      end
      OFS_POWER_STATUS: begin
        next_rdata[2:0] = state;
        next_rdata[3]   = self_refresh_ack;
        next_rdata[4]   = battery_fault_n;
      end
      default:             next_rdata = RESET_ZERO;
    endcase
  end

  // Wake sources; a masked pin still wakes, it just leaves no pending bit
  assign wake_src = (|pin_hit) || rtc_alarm;
  assign wake_go  = wake_src && battery_fault_n;
  assign count_done = ({16'h0000, wake_count} ==
                       WAKE_RST_CYCLES - 32'd1);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_RUN;
    end else begin
      unique case (state)
        ST_RUN: begin
          // Software has already parked memory and pads before this write
          if (clock_gate_ctrl[1]) begin
            state <= ST_SLEEP;
          end else if (clock_gate_ctrl[0]) begin
            state <= ST_IDLE_REQ;
          end
        end
        ST_IDLE_REQ: if (cpu_idle_ack) begin
          state <= ST_IDLE;
        end
        ST_IDLE: if (idle_wake_irq || wake_src) begin
          state <= ST_RUN;
        end
        // SLEEP and IDLE both watch the pins as wake sources; elsewhere they are
        // ordinary interrupt requests
        ST_SLEEP: if (wake_go) begin
          state <= ST_WAKE_RST;
        end
        ST_WAKE_RST: if (count_done) begin
          state <= ST_RUN;
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_count <= 16'h0000;
    end else if (state == ST_WAKE_RST) begin
      wake_count <= wake_count + 16'h0001;
    end else begin
      wake_count <= 16'h0000;
    end
  end

  // Power and reset pins; registered so no glitch reaches the regulator
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_power_enable <= 1'b1;
      core_reset_n      <= 1'b0;
      idle_request      <= 1'b0;
      idle_mode         <= 1'b0;
    end else begin
      core_power_enable <= !(state == ST_SLEEP && !wake_go);
      core_reset_n      <= !(state == ST_WAKE_RST && !count_done) &&
                           !(state == ST_SLEEP && wake_go);
      idle_request      <= state == ST_IDLE_REQ && !cpu_idle_ack;
      idle_mode         <= (state == ST_IDLE_REQ && cpu_idle_ack) ||
                           (state == ST_IDLE && !idle_wake_irq &&
                            !wake_src);
    end
  end

  // Mode bits live in the core domain, so the wake reset clears them too
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clock_gate_ctrl <= 2'b00;
    end else if (state == ST_WAKE_RST) begin
      clock_gate_ctrl <= 2'b00;
    end else if (state == ST_IDLE && (idle_wake_irq || wake_src)) begin
      clock_gate_ctrl[0] <= 1'b0;
    end else if (wr && req.addr == OFS_CLOCK_GATE_CTRL) begin
      clock_gate_ctrl <= hwdata[SLEEP_BIT:IDLE_BIT];
    end
  end

  // Always-on settings, untouched by the wake reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      misc_control   <= RESET_ZERO;
      general_status <= RESET_ZERO;
    end else begin
      if (wr && req.addr == OFS_MISC_CONTROL) begin
        misc_control <= hwdata;
      end
      if (wr && req.addr == OFS_GENERAL_STATUS) begin
        general_status <= hwdata;
      end
    end
  end

  // Protection holds any value but the two documented ones unchanged
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdram_protect    <= SDRAM_RELEASE;
      usb_pad_ctrl     <= 2'b00;
      data_pullup_ctrl <= 2'b00;
    end else begin
      if (misc_control[SDRAM_LSB +: 3] == SDRAM_PROTECT) begin
        sdram_protect <= SDRAM_PROTECT;
      end else if (misc_control[SDRAM_LSB +: 3] == SDRAM_RELEASE) begin
        sdram_protect <= SDRAM_RELEASE;
      end
      usb_pad_ctrl     <= misc_control[USB_LSB +: 2];
      data_pullup_ctrl <= misc_control[PULLUP_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdram_self_refresh <= 1'b0;
    end else if (wr && req.addr == OFS_REFRESH_CTRL) begin
      sdram_self_refresh <= hwdata[SELF_REF_BIT];
    end
  end

  // Write one clears; a wake arriving on the clearing edge wins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_flag <= 1'b0;
    end else if (state == ST_SLEEP && wake_go) begin
      wake_flag <= 1'b1;
    end else if (wr && req.addr == OFS_GENERAL_STATUS2 &&
                 hwdata[WAKE_FLAG_BIT]) begin
      wake_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_irq_mask <= MASK_RESET;
      ext_irq_func <= 16'h0000;
      for (int i = 0; i < EXT_PINS; i++) begin
        trig_mode[i] <= TRIG_LOW;
      end
    end else begin
      if (wr && req.addr == OFS_EXT_IRQ_MASK) begin
        ext_irq_mask <= hwdata[15:0];
      end
      if (wr && req.addr == OFS_EXT_IRQ_FUNC) begin
        ext_irq_func <= hwdata[15:0];
      end
      for (int i = 0; i < PINS_PER_TRIG; i++) begin
        if (wr && req.addr == OFS_TRIG_LOW) begin
          trig_mode[i] <= hwdata[i*TRIG_STRIDE +: 3];
        end
        if (wr && req.addr == OFS_TRIG_HIGH) begin
          trig_mode[i + PINS_PER_TRIG] <= hwdata[i*TRIG_STRIDE +: 3];
        end
      end
    end
  end

  // Pending bits; low pins go to source pending only, the rest elsewhere
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_irq_pending <= 16'h0000;
      source_pending  <= 6'h00;
    end else begin
      for (int i = 0; i < EXT_PINS; i++) begin
        if (pin_hit[i] && !ext_irq_mask[i] && i >= LOW_PINS) begin
          ext_irq_pending[i] <= 1'b1;
        end else if (wr && req.addr == OFS_EXT_IRQ_PENDING &&
                     hwdata[i]) begin
          ext_irq_pending[i] <= 1'b0;
        end
      end
      for (int i = 0; i < 6; i++) begin
        if ((i < LOW_PINS && pin_hit[i] && !ext_irq_mask[i]) ||
            (i == SRC_RTC_BIT && rtc_alarm)) begin
          source_pending[i] <= 1'b1;
        end else if (wr && req.addr == OFS_SOURCE_PENDING && hwdata[i]) begin
          source_pending[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_irq_request <= 1'b0;
    end else begin
      ext_irq_request <= (|ext_irq_pending) || (|source_pending);
    end
  end

endmodule
`default_nettype wire

// ===== sleep_wakeup_power_sequencer_tb.sv
// Register-driven tests of sleep, idle and wake-up sequencing
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_power_sequencer_tb
  import power_seq_pkg::*;
;
  localparam int unsigned N = 16;
  logic        ref_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0]  htrans = 2'h0, usb_pad_ctrl, data_pullup_ctrl;
  logic [15:0] pin = 16'h0;
  logic        rtc = 1'b0, batt_n = 1'b1, wake_irq = 1'b0;
  logic        hreadyout, hresp, cpe, crn, ireq, imode, sref, irq;
  logic        ack, sack, rail;
  logic [2:0]  prot;
  int          fail_count = 0, total_checks = 0, n;

  always #12.5 ref_clk = ~ref_clk;

  sleep_wakeup_power_sequencer #(.WAKE_RST_CYCLES(N)) dut_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_irq_pin(pin), .rtc_alarm(rtc),
    .battery_fault_n(batt_n), .cpu_idle_ack(ack), .idle_wake_irq(wake_irq),
    .self_refresh_ack(sack), .core_power_enable(cpe), .core_reset_n(crn),
    .idle_request(ireq), .idle_mode(imode), .sdram_protect(prot),
    .usb_pad_ctrl(usb_pad_ctrl), .data_pullup_ctrl(data_pullup_ctrl),
    .sdram_self_refresh(sref), .ext_irq_request(irq));

  power_far_side #(.DLY(3)) far_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .core_power_enable(cpe),
    .idle_request(ireq), .sdram_self_refresh(sref), .rail_on(rail),
    .cpu_idle_ack(ack), .self_refresh_ack(sack));

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  // Held until hready is seen high, as a single-word master must
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    // Outputs registered from the new value settle one edge later
    @(posedge ref_clk);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic sleep_go;
    wr(OFS_EXT_IRQ_PENDING, 32'hffff_ffff);
    wr(OFS_SOURCE_PENDING, 32'hffff_ffff);
    wr(OFS_MISC_CONTROL, 32'h000e_3001);
    wr(OFS_CLOCK_GATE_CTRL, 32'h8);
    repeat (20) if (cpe !== 1'b0) @(posedge ref_clk);
    chk("rail", 32'h0, {31'h0, rail});
  endtask

  task automatic wake_chk;
    repeat (200) if (cpe !== 1'b1) @(posedge ref_clk);
    chk("wake_reset", 32'h0, {31'h0, crn});
    n = 0;
    while (crn !== 1'b1 && n < 100) begin
      n++;
      @(posedge ref_clk);
    end
    chk("reset_len", N, n);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd("mask", OFS_EXT_IRQ_MASK, {16'h0, MASK_RESET});
    rd("unmapped", 8'hfc, 32'h0);
    chk("power_on", 32'h1, {31'h0, cpe});
    $display("test reset done");
    wr(OFS_MISC_CONTROL, 32'h3001);
    chk("usb", 32'h3, {30'h0, usb_pad_ctrl});
    chk("pullup", 32'h1, {30'h0, data_pullup_ctrl});
    wr(OFS_GENERAL_STATUS, 32'h18);
    wr(OFS_REFRESH_CTRL, 32'h0040_0000);
    chk("self_ref", 32'h1, {31'h0, sref});
    repeat (6) @(posedge ref_clk);
    rd("pwr_status", OFS_POWER_STATUS, 32'h18);
    wr(OFS_MISC_CONTROL, 32'h000e_3001);
    chk("protect", 32'h7, {29'h0, prot});
    wr(OFS_MISC_CONTROL, 32'h000a_3001);
    chk("protect_hold", 32'h7, {29'h0, prot});
    $display("test control fields done");
    wr(OFS_CLOCK_GATE_CTRL, 32'h4);
    repeat (30) if (ireq !== 1'b1) @(posedge ref_clk);
    chk("idle_req", 32'h1, {31'h0, ireq});
    repeat (30) if (imode !== 1'b1) @(posedge ref_clk);
    chk("idle", 32'h1, {31'h0, imode});
    wake_irq <= 1'b1;
    repeat (30) if (imode !== 1'b0) @(posedge ref_clk);
    wake_irq <= 1'b0;
    rd("idle_clear", OFS_CLOCK_GATE_CTRL, 32'h0);
    $display("test idle done");
    // Pin 5 rising and unmasked, pin 1 high level but masked
    wr(OFS_EXT_IRQ_FUNC, 32'h22);
    wr(OFS_TRIG_LOW, 32'h0030_0010);
    wr(OFS_EXT_IRQ_MASK, 32'hffdf);
    sleep_go();
    batt_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    pin[5] <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk("batt_block", 32'h0, {31'h0, cpe});
    pin[5] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    batt_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pin[5] <= 1'b1;
    wake_chk();
    rd("user_bits", OFS_GENERAL_STATUS, 32'h18);
    rd("wake_flag", OFS_GENERAL_STATUS2, 32'h4);
    rd("ext_pend", OFS_EXT_IRQ_PENDING, 32'h20);
    rd("src_pend", OFS_SOURCE_PENDING, 32'h0);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFS_MISC_CONTROL, 32'h3001);
    chk("release", 32'h0, {29'h0, prot});
    pin[5] <= 1'b0;
    $display("test pin wake done");
    sleep_go();
    pin[1] <= 1'b1;
    wake_chk();
    rd("masked_pend", OFS_SOURCE_PENDING, 32'h0);
    pin[1] <= 1'b0;
    sleep_go();
    rtc <= 1'b1;
    wake_chk();
    rtc <= 1'b0;
    rd("rtc_pend", OFS_SOURCE_PENDING, 32'h20);
    $display("test masked and alarm wake done");
    end_of_test();
  end
endmodule
`default_nettype wire
